// *** shared/synth_loop_pkg.sv ***
// Package: register map, field layout, reset values and loop constants
// for the main synthesizer loop divider control.
// Assumes one 125 MHz clock domain and an 8-bit register port.
`default_nettype none

package synth_loop_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] OFS_LOOP_CTRL = 9'h101;
  localparam logic [8:0] OFS_CP_CODE = 9'h102;
  localparam logic [8:0] OFS_REF_DIV = 9'h105;
  localparam logic [8:0] OFS_INT_DIV = 9'h106;
  localparam logic [8:0] OFS_FRAC_0 = 9'h107;
  localparam logic [8:0] OFS_FRAC_1 = 9'h108;
  localparam logic [8:0] OFS_FRAC_2 = 9'h109;
  localparam logic [8:0] OFS_MOD_0 = 9'h10a;
  localparam logic [8:0] OFS_MOD_1 = 9'h10b;
  localparam logic [8:0] OFS_MOD_2 = 9'h10c;
  localparam logic [8:0] OFS_CASC_LO = 9'h10e;
  localparam logic [8:0] OFS_CASC_HI = 9'h10f;
  localparam logic [8:0] OFS_POST_DIV0 = 9'h110;
  localparam logic [8:0] OFS_POST_DIV1 = 9'h111;
  localparam logic [8:0] OFS_CHAN_DIV0 = 9'h112;
  localparam logic [8:0] OFS_ZD_DIV = 9'h116;
  localparam logic [8:0] OFS_CHAN_SRC = 9'h117;
  localparam logic [8:0] OFS_STATUS = 9'h118;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_DOUBLER = 3;
  localparam int BIT_MODE_HI = 2;
  localparam int BIT_MODE_LO = 1;
  localparam int BIT_SDM_PD = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_LOOP_CTRL = 8'h00;
  localparam logic [7:0] RST_CP_CODE = 8'h8d;
  localparam logic [5:0] RST_REF_DIV = 6'h01;
  localparam logic [7:0] RST_INT_DIV = 8'h32;
  localparam logic [23:0] RST_FRAC = 24'h000000;
  localparam logic [23:0] RST_MOD = 24'h000001;
  localparam logic [11:0] RST_CASC = 12'h004;
  localparam logic [3:0] RST_POST_DIV = 4'h2;
  localparam logic [5:0] RST_CHAN_DIV = 6'h00;

  // ----------------------------------------------------------------
  // Limits and forced analog settings
  // ----------------------------------------------------------------
  localparam logic [11:0] CASC_MIN = 12'h004;
  localparam logic [3:0] POST_MIN = 4'h2;
  localparam logic [3:0] POST_MAX = 4'hb;
  localparam logic [10:0] CP_STEP_UA = 11'h004;
  localparam logic [10:0] CP_FORCE_UA = 11'h400;
  localparam logic [6:0] SECOND_POLE_CAPACITOR_LOW_RATE_PF = 7'h64;
  localparam logic [6:0] SECOND_POLE_CAPACITOR_NORMAL_PF = 7'h10;
  localparam int NUM_GROUPS = 4;
  localparam int NUM_OUTS = 10;

  typedef enum logic [1:0] {
    MODE_FRAC_INT = 2'b00,
    MODE_LOW_RATE = 2'b01,
    MODE_ZERO_DELAY = 2'b10,
    MODE_RESERVED = 2'b11
  } loop_mode_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [10:0] cp_current_ua;
    logic zero_res_short;
    logic [6:0] second_pole_capacitor_pf;
    logic sdm_powered;
  } analog_cfg_t;

endpackage

`default_nettype wire

// *** src/tick_divider.sv ***
// Counts input ticks and emits a one-cycle pulse every ratio ticks.
// Assumes ticks are synchronous one-cycle pulses; ratio 0 acts as 1.
`default_nettype none

module tick_divider #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Divider
  input wire logic tick,
  input wire logic [W-1:0] ratio,
  output var logic pulse
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic pulse_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    pulse_nxt = 1'b0;
    if (tick) begin
      // Ratio change mid-count takes effect at the next wrap or sooner
      if (cnt_r + W'(1) >= ratio) begin
        cnt_nxt = '0;
        pulse_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      pulse <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pulse <= pulse_nxt;
    end
  end

endmodule

`default_nettype wire

// *** src/synth_loop_ctrl.sv ***
// Main synthesizer loop: reference scaling, loop mode selection,
// feedback dividers with modulator, post and channel dividers.
// Assumes ref_level and vco_tick are sampled synchronous to ref_clk.
//
// Added by the designer: the address-and-strobe port.
`default_nettype none

// How it works
// [R01] Doubler bit set: phase detector ticks on both reference edges, divider bypassed.
// [R02] Doubler clear: phase detector tick every reference-divide-ratio rising edges, 1..63.
// [R03] Two-bit mode picks fractional/integer, low-rate cascade or zero-delay feedback.
// [R04] Only fractional/integer mode divides by integer plus fraction over modulus.
// [R05] Modulator power-down bit forces integer-only division.
// [R06] Zero fraction gives integer division while the modulator stays powered.
// [R07] Software keeps integer value 12..255 for integer-only use.
// [R08] Software keeps integer value 15..252 for fractional use.
// [R09] Software keeps fraction below modulus, both within 24 bits.
// [R10] Software scales fraction and modulus up for best performance.
// [R11] Low-rate mode feeds back through integer divider then cascade divider.
// [R12] Low-rate mode forces charge pump current to 1024 uA.
// [R13] Low-rate mode shorts zero resistor and sets pole capacitor 100 pF.
// [R14] Software powers modulator down or zeroes fraction before low-rate mode.
// [R15] Software keeps integer value 12..255 in low-rate mode.
// [R16] Cascade ratio is 12 bits: low byte plus low nibble of next register.
// [R17] Cascade divides by 4..4095; smaller values are illegal.
// [R18] Post dividers run 2..11; each group picks either post divider.
// [R19] Channel dividers run 1..64 behind their selected post divider.
// [R20] Ten outputs in four groups, each group with its own channel divider.
// [R21] Zero-delay feedback is first post divider times zero-delay divider.
// [R22] Cascade ratio reaches the divider only as one complete word.
module synth_loop_ctrl
  import synth_loop_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire synth_loop_pkg::reg_req_t req,
  output var logic [7:0] rd_data_r,
  // Reference and oscillator
  input wire logic ref_level,
  input wire logic vco_tick,
  // Loop outputs
  output var logic pfd_ref_tick_r,
  output var logic pfd_fb_tick_r,
  output var logic [9:0] out_tick_r,
  output var synth_loop_pkg::analog_cfg_t analog_r
);
  import synth_loop_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] cp_code_r, cp_code_nxt;
  logic [5:0] ref_div_r, ref_div_nxt;
  logic [7:0] int_div_r, int_div_nxt;
  logic [23:0] frac_r, frac_nxt;
  logic [23:0] mod_r, mod_nxt;
  logic [7:0] casc_lo_r, casc_lo_nxt;
  logic [3:0] casc_hi_r, casc_hi_nxt;
  logic [11:0] casc_word_r, casc_word_nxt;
  logic [3:0] post_r [2];
  logic [3:0] post_nxt [2];
  logic [5:0] chan_r [NUM_GROUPS];
  logic [5:0] chan_nxt [NUM_GROUPS];
  logic [5:0] zd_r, zd_nxt;
  logic [3:0] src_r, src_nxt;
  logic [7:0] rd_nxt;
  loop_mode_t mode;
  logic sdm_on;

  assign mode = loop_mode_t'(ctrl_r[BIT_MODE_HI:BIT_MODE_LO]);

  function automatic logic [7:0] byte_of(input logic [23:0] w, input logic [1:0] k);
    byte_of = w[8*k +: 8];
  endfunction

  always_comb begin
    ctrl_nxt = ctrl_r;
    cp_code_nxt = cp_code_r;
    ref_div_nxt = ref_div_r;
    int_div_nxt = int_div_r;
    frac_nxt = frac_r;
    mod_nxt = mod_r;
    casc_lo_nxt = casc_lo_r;
    casc_hi_nxt = casc_hi_r;
    casc_word_nxt = casc_word_r;
    post_nxt = post_r;
    chan_nxt = chan_r;
    zd_nxt = zd_r;
    src_nxt = src_r;
    rd_nxt = 8'h00;
    if (req.wr) begin
      case (req.addr)
        OFS_LOOP_CTRL: ctrl_nxt = {4'h0, req.wdata[3:0]};
        OFS_CP_CODE: cp_code_nxt = req.wdata;
        OFS_REF_DIV: ref_div_nxt = req.wdata[5:0];
        OFS_INT_DIV: int_div_nxt = req.wdata;
        OFS_FRAC_0: frac_nxt[7:0] = req.wdata;
        OFS_FRAC_1: frac_nxt[15:8] = req.wdata;
        OFS_FRAC_2: frac_nxt[23:16] = req.wdata;
        OFS_MOD_0: mod_nxt[7:0] = req.wdata;
        OFS_MOD_1: mod_nxt[15:8] = req.wdata;
        OFS_MOD_2: mod_nxt[23:16] = req.wdata;
        // Low byte waits; the high-nibble write commits the whole word
        OFS_CASC_LO: casc_lo_nxt = req.wdata; // [R16] [R22]
        OFS_CASC_HI: begin
          casc_hi_nxt = req.wdata[3:0];
          casc_word_nxt = {req.wdata[3:0], casc_lo_r}; // [R16] [R22]
        end
        OFS_POST_DIV0: post_nxt[0] = req.wdata[3:0];
        OFS_POST_DIV1: post_nxt[1] = req.wdata[3:0];
        OFS_ZD_DIV: zd_nxt = req.wdata[5:0];
        OFS_CHAN_SRC: src_nxt = req.wdata[3:0];
        default: begin
          for (int g = 0; g < NUM_GROUPS; g++) begin
            if (req.addr == OFS_CHAN_DIV0 + 9'(g)) begin
              chan_nxt[g] = req.wdata[5:0];
            end
          end
        end
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        OFS_LOOP_CTRL: rd_nxt = ctrl_r;
        OFS_CP_CODE: rd_nxt = cp_code_r;
        OFS_REF_DIV: rd_nxt = {2'b00, ref_div_r};
        OFS_INT_DIV: rd_nxt = int_div_r;
        OFS_FRAC_0: rd_nxt = byte_of(frac_r, 2'd0);
        OFS_FRAC_1: rd_nxt = byte_of(frac_r, 2'd1);
        OFS_FRAC_2: rd_nxt = byte_of(frac_r, 2'd2);
        OFS_MOD_0: rd_nxt = byte_of(mod_r, 2'd0);
        OFS_MOD_1: rd_nxt = byte_of(mod_r, 2'd1);
        OFS_MOD_2: rd_nxt = byte_of(mod_r, 2'd2);
        OFS_CASC_LO: rd_nxt = casc_lo_r;
        OFS_CASC_HI: rd_nxt = {4'h0, casc_hi_r};
        OFS_POST_DIV0: rd_nxt = {4'h0, post_r[0]};
        OFS_POST_DIV1: rd_nxt = {4'h0, post_r[1]};
        OFS_ZD_DIV: rd_nxt = {2'b00, zd_r};
        OFS_CHAN_SRC: rd_nxt = {4'h0, src_r};
        OFS_STATUS: rd_nxt = {4'h0, analog_r.zero_res_short, sdm_on, mode};
        default: begin
          for (int g = 0; g < NUM_GROUPS; g++) begin
            if (req.addr == OFS_CHAN_DIV0 + 9'(g)) begin
              rd_nxt = {2'b00, chan_r[g]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= RST_LOOP_CTRL;
      cp_code_r <= RST_CP_CODE;
      ref_div_r <= RST_REF_DIV;
      int_div_r <= RST_INT_DIV;
      frac_r <= RST_FRAC;
      mod_r <= RST_MOD;
      casc_lo_r <= RST_CASC[7:0];
      casc_hi_r <= RST_CASC[11:8];
      casc_word_r <= RST_CASC;
      post_r <= '{default: RST_POST_DIV};
      chan_r <= '{default: RST_CHAN_DIV};
      zd_r <= RST_CHAN_DIV;
      src_r <= 4'h0;
      rd_data_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      cp_code_r <= cp_code_nxt;
      ref_div_r <= ref_div_nxt;
      int_div_r <= int_div_nxt;
      frac_r <= frac_nxt;
      mod_r <= mod_nxt;
      casc_lo_r <= casc_lo_nxt;
      casc_hi_r <= casc_hi_nxt;
      casc_word_r <= casc_word_nxt;
      post_r <= post_nxt;
      chan_r <= chan_nxt;
      zd_r <= zd_nxt;
      src_r <= src_nxt;
      rd_data_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reference scaling
  // ----------------------------------------------------------------
  logic ref_d_r;
  logic ref_rise;
  logic ref_edge;
  logic ref_div_pulse;
  logic pfd_ref_nxt;
  logic [5:0] ref_ratio;

  assign ref_rise = ref_level & ~ref_d_r;
  assign ref_edge = ref_level ^ ref_d_r;
  assign ref_ratio = (ref_div_r == 6'h00) ? 6'h01 : ref_div_r;

  tick_divider #(.W(6)) u_ref_div (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(ref_rise),
    .ratio(ref_ratio),
    .pulse(ref_div_pulse)
  );

  always_comb begin
    if (ctrl_r[BIT_DOUBLER]) begin
      pfd_ref_nxt = ref_edge; // [R01]
    end else begin
      pfd_ref_nxt = ref_div_pulse; // [R02]
    end
  end

  // ----------------------------------------------------------------
  // Feedback path and modulator
  // ----------------------------------------------------------------
  logic [23:0] acc_r, acc_nxt;
  logic [8:0] int_ratio_r, int_ratio_nxt;
  logic [24:0] acc_sum;
  logic int_pulse;
  logic casc_pulse;
  logic zd_pulse;
  logic pfd_fb_nxt;
  logic [11:0] casc_ratio;
  logic [1:0] post_pulse;
  logic [NUM_GROUPS-1:0] chan_pulse;
  logic [9:0] out_nxt;
  analog_cfg_t analog_nxt;

  // Fraction only in the fractional mode and with a powered, nonzero modulator
  assign sdm_on = (mode == MODE_FRAC_INT) && !ctrl_r[BIT_SDM_PD]
                  && (frac_r != 24'h0) && (mod_r != 24'h0); // [R04] [R05] [R06] [R11]
  assign acc_sum = {1'b0, acc_r} + {1'b0, frac_r};
  // Invalid low settings held at the minimum rather than stalling the loop
  assign casc_ratio = (casc_word_r < CASC_MIN) ? CASC_MIN : casc_word_r; // [R17]

  always_comb begin
    acc_nxt = acc_r;
    int_ratio_nxt = int_ratio_r;
    if (!sdm_on) begin
      acc_nxt = 24'h0;
      int_ratio_nxt = {1'b0, int_div_r}; // [R05] [R06]
    end else if (int_pulse || int_ratio_r == 9'h0) begin
      // First-order carry: n+1 on frac out of mod cycles
      if (acc_sum >= {1'b0, mod_r}) begin
        acc_nxt = 24'(acc_sum - {1'b0, mod_r});
        int_ratio_nxt = {1'b0, int_div_r} + 9'h1; // [R04]
      end else begin
        acc_nxt = acc_sum[23:0];
        int_ratio_nxt = {1'b0, int_div_r};
      end
    end
  end

  tick_divider #(.W(9)) u_int_div (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(vco_tick),
    .ratio(int_ratio_r),
    .pulse(int_pulse)
  );

  tick_divider #(.W(12)) u_casc_div (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(int_pulse),
    .ratio(casc_ratio),
    .pulse(casc_pulse)
  );

  // ----------------------------------------------------------------
  // Post and channel dividers
  // ----------------------------------------------------------------
  function automatic logic [3:0] post_clamp(input logic [3:0] v);
    if (v < POST_MIN) begin
      post_clamp = POST_MIN;
    end else if (v > POST_MAX) begin
      post_clamp = POST_MAX;
    end else begin
      post_clamp = v;
    end
  endfunction

  // Output index to its group: 0..3, 4..5, 6..7, 8..9
  function automatic int group_of(input int o);
    group_of = (o < 4) ? 0 : (o < 6) ? 1 : (o < 8) ? 2 : 3;
  endfunction

  for (genvar p = 0; p < 2; p++) begin : g_post
    tick_divider #(.W(4)) u_post (
      .clk(ref_clk),
      .rst_n(rst_n),
      .tick(vco_tick),
      .ratio(post_clamp(post_r[p])), // [R18]
      .pulse(post_pulse[p])
    );
  end

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_chan
    tick_divider #(.W(7)) u_chan (
      .clk(ref_clk),
      .rst_n(rst_n),
      .tick(post_pulse[src_r[g]]), // [R18] [R19] [R20]
      .ratio({1'b0, chan_r[g]} + 7'h1), // [R19]
      .pulse(chan_pulse[g])
    );
  end

  tick_divider #(.W(7)) u_zd_div (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(post_pulse[0]),
    .ratio({1'b0, zd_r} + 7'h1), // [R21]
    .pulse(zd_pulse)
  );

  always_comb begin
    for (int o = 0; o < NUM_OUTS; o++) begin
      out_nxt[o] = chan_pulse[group_of(o)]; // [R20]
    end
  end

  // ----------------------------------------------------------------
  // Loop mode selection and forced analog settings
  // ----------------------------------------------------------------
  always_comb begin
    case (mode)
      MODE_LOW_RATE: pfd_fb_nxt = casc_pulse; // [R03] [R11]
      MODE_ZERO_DELAY: pfd_fb_nxt = zd_pulse; // [R03] [R21]
      default: pfd_fb_nxt = int_pulse; // [R03]
    endcase
    analog_nxt.sdm_powered = !ctrl_r[BIT_SDM_PD]; // [R05] [R06]
    if (mode == MODE_LOW_RATE) begin
      analog_nxt.cp_current_ua = CP_FORCE_UA; // [R12]
      analog_nxt.zero_res_short = 1'b1; // [R13]
      analog_nxt.second_pole_capacitor_pf = SECOND_POLE_CAPACITOR_LOW_RATE_PF; // [R13]
    end else begin
      analog_nxt.cp_current_ua = 11'({3'b000, cp_code_r} * CP_STEP_UA);
      analog_nxt.zero_res_short = 1'b0;
      analog_nxt.second_pole_capacitor_pf = SECOND_POLE_CAPACITOR_NORMAL_PF;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_r <= 1'b0;
      acc_r <= 24'h0;
      int_ratio_r <= 9'h0;
      pfd_ref_tick_r <= 1'b0;
      pfd_fb_tick_r <= 1'b0;
      out_tick_r <= 10'h000;
      analog_r <= '0;
    end else begin
      ref_d_r <= ref_level;
      acc_r <= acc_nxt;
      int_ratio_r <= int_ratio_nxt;
      pfd_ref_tick_r <= pfd_ref_nxt;
      pfd_fb_tick_r <= pfd_fb_nxt;
      out_tick_r <= out_nxt;
      analog_r <= analog_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_hi_write;
    req.wr && req.addr == OFS_CASC_HI;
  endsequence

  property p_doubler;
    @(posedge ref_clk) disable iff (!rst_n)
      ctrl_r[BIT_DOUBLER] && ref_edge |=> pfd_ref_tick_r;
  endproperty
  a_doubler: assert property (p_doubler) else $error("doubler edge lost"); // [R01]

  property p_refdiv;
    @(posedge ref_clk) disable iff (!rst_n)
      !ctrl_r[BIT_DOUBLER] |=> pfd_ref_tick_r == $past(ref_div_pulse);
  endproperty
  a_refdiv: assert property (p_refdiv) else $error("ref divider not used"); // [R02]

  property p_low_rate_fb;
    @(posedge ref_clk) disable iff (!rst_n)
      mode == MODE_LOW_RATE |=> pfd_fb_tick_r == $past(casc_pulse);
  endproperty
  a_low_rate_fb: assert property (p_low_rate_fb) else $error("cascade not fed back"); // [R11]

  property p_sdm_pd;
    @(posedge ref_clk) disable iff (!rst_n)
      ctrl_r[BIT_SDM_PD] ##1 ctrl_r[BIT_SDM_PD] |-> int_ratio_r == {1'b0, $past(int_div_r)};
  endproperty
  a_sdm_pd: assert property (p_sdm_pd) else $error("fraction active in power-down"); // [R05]

  property p_frac_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      frac_r == 24'h0 && !ctrl_r[BIT_SDM_PD] |=> analog_r.sdm_powered && !$past(sdm_on);
  endproperty
  a_frac_zero: assert property (p_frac_zero) else $error("zero fraction handling"); // [R06]

  property p_cp_force;
    @(posedge ref_clk) disable iff (!rst_n)
      mode == MODE_LOW_RATE |=> analog_r.cp_current_ua == 11'h400;
  endproperty
  a_cp_force: assert property (p_cp_force) else $error("charge pump not forced"); // [R12]

  property p_filter_force;
    @(posedge ref_clk) disable iff (!rst_n)
      mode == MODE_LOW_RATE |=> analog_r.zero_res_short && analog_r.second_pole_capacitor_pf == 7'h64;
  endproperty
  a_filter_force: assert property (p_filter_force) else $error("filter not forced"); // [R13]

  property p_casc_commit;
    @(posedge ref_clk) disable iff (!rst_n)
      s_hi_write |=> casc_word_r == {$past(req.wdata[3:0]), $past(casc_lo_r)};
  endproperty
  a_casc_commit: assert property (p_casc_commit) else $error("cascade word wrong"); // [R16]

  property p_casc_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      req.wr && req.addr == OFS_CASC_LO |=> $stable(casc_word_r);
  endproperty
  a_casc_hold: assert property (p_casc_hold) else $error("partial cascade applied"); // [R22]

  property p_casc_min;
    @(posedge ref_clk) disable iff (!rst_n)
      casc_ratio >= 12'h004 and (casc_word_r >= 12'h004 |-> casc_ratio == casc_word_r);
  endproperty
  a_casc_min: assert property (p_casc_min) else $error("cascade ratio out of range"); // [R17]

  property p_zd_fb;
    @(posedge ref_clk) disable iff (!rst_n)
      mode == MODE_ZERO_DELAY |=> pfd_fb_tick_r == $past(zd_pulse);
  endproperty
  a_zd_fb: assert property (p_zd_fb) else $error("zero-delay feedback wrong"); // [R21]

  property p_group_out;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> out_tick_r[5:4] == {2{$past(chan_pulse[1])}}
               && out_tick_r[0] == $past(chan_pulse[0]);
  endproperty
  a_group_out: assert property (p_group_out) else $error("output grouping wrong"); // [R20]

endmodule

`default_nettype wire

// *** test/ref_source.sv ***
// Reference source model: square wave on the active reference line.
// Assumes the bench clock; the line stands low while the source is off.
`default_nettype none

module ref_source #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic clk,
  // Control
  input wire logic en,
  // Reference
  output var logic ref_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Waveform
  // ----------------------------------------------------------------
  int cnt = 0;
  initial ref_level = 1'b0;
  // Even halves keep the duty cycle at 50 %, which the doubler needs
  always @(posedge clk) begin
    if (!en) begin
      ref_level <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      ref_level <= ~ref_level;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

`default_nettype wire

// *** test/tb.sv ***
// Bench for the main synthesizer loop divider control.
// Assumes the reference source model and one 125 MHz clock.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import synth_loop_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t req = '0;
  logic [7:0] rd_data_r;
  logic ref_level, ref_q = 1'b0, ref_en = 1'b0;
  logic vco_tick = 1'b0;
  logic pfd_ref_tick_r, pfd_fb_tick_r;
  logic [9:0] out_tick_r;
  analog_cfg_t analog_r;
  int error_cnt = 0, compares = 0;
  int n_edge = 0, n_rise = 0, n_ref = 0, n_fb = 0, n_o0 = 0, n_o9 = 0;

  always #4 ref_clk = ~ref_clk;

  synth_loop_ctrl synth_loop_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
    .rd_data_r(rd_data_r), .ref_level(ref_level), .vco_tick(vco_tick),
    .pfd_ref_tick_r(pfd_ref_tick_r), .pfd_fb_tick_r(pfd_fb_tick_r),
    .out_tick_r(out_tick_r), .analog_r(analog_r));
  ref_source #(.HALF(3)) ref_source_inst (.clk(ref_clk), .en(ref_en), .ref_level(ref_level));

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    ref_q <= ref_level;
    n_edge <= n_edge + int'(ref_level !== ref_q);
    n_rise <= n_rise + int'(ref_level && !ref_q);
    n_ref <= n_ref + int'(pfd_ref_tick_r === 1'b1);
    n_fb <= n_fb + int'(pfd_fb_tick_r === 1'b1);
    n_o0 <= n_o0 + int'(out_tick_r[0] === 1'b1);
    n_o9 <= n_o9 + int'(out_tick_r[9] === 1'b1);
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    req <= '0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    req <= '0;
    #1 chk(16'(rd_data_r), 16'(exp));
    @(posedge ref_clk);
  endtask

  // Holds vco_tick for n edges, then lets the divider chain drain
  task automatic vco_fb(input int n, input int exp);
    int f0;
    f0 = n_fb;
    vco_tick <= 1'b1;
    repeat (n) @(posedge ref_clk);
    vco_tick <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(16'(n_fb - f0), 16'(exp));
  endtask

  // Runs the reference for twelve rises; exp is divided edge count
  task automatic ref_run(input int div, input logic both);
    int r0, e0, p0;
    {r0, e0, p0} = {n_rise, n_edge, n_ref};
    ref_en <= 1'b1;
    repeat (72) @(posedge ref_clk);
    ref_en <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(16'(n_ref - p0), 16'(both ? n_edge - e0 : (n_rise - r0) / div));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_LOOP_CTRL, 8'h00);
    rd(OFS_REF_DIV, 8'h01);
    rd(OFS_CASC_LO, 8'h04);
    rd(OFS_CASC_HI, 8'h00);
    rd(9'h1ff, 8'h00);
    chk(16'(analog_r.cp_current_ua), 16'd564);
    chk(16'(analog_r.second_pole_capacitor_pf), 16'd16);
    chk(16'(analog_r.sdm_powered), 16'h1);
  endtask

  task automatic t_ref();
    wr(OFS_REF_DIV, 8'h03);
    ref_run(3, 1'b0);
    wr(OFS_LOOP_CTRL, 8'h08);
    ref_run(1, 1'b1);
  endtask

  task automatic t_low_rate();
    wr(OFS_INT_DIV, 8'h0c);
    wr(OFS_CASC_LO, 8'h05);
    wr(OFS_CASC_HI, 8'h00);
    wr(OFS_LOOP_CTRL, 8'h03);
    rd(OFS_CASC_LO, 8'h05);
    rd(OFS_STATUS, 8'h09);
    chk(16'(analog_r.cp_current_ua), 16'd1024);
    chk(16'(analog_r.second_pole_capacitor_pf), 16'd100);
    chk(16'(analog_r.zero_res_short), 16'h1);
    chk(16'(analog_r.sdm_powered), 16'h0);
    vco_fb(120, 2);
  endtask

  task automatic t_frac();
    wr(OFS_LOOP_CTRL, 8'h00);
    vco_fb(120, 10);
    wr(OFS_INT_DIV, 8'h0f);
    // One half, scaled so the modulus fills the field; modulus first keeps fraction below it
    wr(OFS_MOD_0, 8'hfe);
    wr(OFS_MOD_1, 8'hff);
    wr(OFS_MOD_2, 8'hff);
    wr(OFS_FRAC_0, 8'hff);
    wr(OFS_FRAC_1, 8'hff);
    wr(OFS_FRAC_2, 8'h7f);
    vco_fb(124, 8);
    wr(OFS_LOOP_CTRL, 8'h01);
    vco_fb(120, 8);
  endtask

  task automatic t_zero_delay();
    int o0, o9;
    {o0, o9} = {n_o0, n_o9};
    wr(OFS_ZD_DIV, 8'h03);
    wr(OFS_CHAN_DIV0, 8'h04);
    wr(OFS_POST_DIV1, 8'h03);
    wr(OFS_CHAN_SRC, 8'h08);
    wr(OFS_LOOP_CTRL, 8'h04);
    vco_fb(80, 10);
    chk(16'(n_o0 - o0), 16'd8);
    chk(16'(n_o9 - o9), 16'd26);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_ref();
    t_low_rate();
    t_frac();
    t_zero_delay();
    end_of_test();
  end

  // Cuts a hang short
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
